//--- step_attenuator_control_port.sv
`default_nettype none
`include "step_atten_map.svh"
module step_attenuator_control_port #(
  parameter int ATTEN_W   = `ATTEN_W,
  parameter int WORD_W    = `WORD_W,
  parameter int PUP_DELAY = (`PUP_DELAY_US * `CLK_MHZ)
) (
  // Clock, reset, enable
  input  wire logic               mclk_i,
  input  wire logic               rst_i,
  input  wire logic               ce_i,
  // Mode and strobe pins
  input  wire logic               serial_sel_i,
  input  wire logic               latch_strobe_i,
  // Parallel weight lines, 0.5 dB line in bit 0
  input  wire logic [ATTEN_W-1:0] parallel_weight_lines_i,
  // Serial link
  input  wire logic               sclk_i,
  input  wire logic               sdata_i,
  // Attenuator core state and status
  output var  logic [ATTEN_W-1:0] atten_state_o,
  output var  logic               word_top_bit_o,
  output var  logic               pup_busy_o
);
  localparam int CW = $clog2(PUP_DELAY + 1);

  logic [WORD_W-1:0]  shift_word;
  logic [WORD_W+ATTEN_W+1:0] raw_in;
  logic [WORD_W+ATTEN_W+1:0] sync_in;
  logic [WORD_W-1:0]  s_word;
  logic [ATTEN_W-1:0] s_lines;
  logic               s_sel;
  logic               s_le;
  logic               le_d;
  logic               le_rise;
  logic [CW-1:0]      pup_cnt;
  step_atten_pkg::pup_state_e state;
  step_atten_pkg::pup_state_e next_state;
  logic [ATTEN_W-1:0] next_atten;

  // Shift register lives in the serial clock domain
  serial_shifter #(.W(WORD_W)) u_shift (
    .sclk_i (sclk_i),
    .sdata_i(sdata_i),
    .word_o (shift_word)
  );

  // Pin inputs and shift contents enter the system domain. The shift word is
  // stable while the strobe is high, so sampling it then is safe.
  assign raw_in = {serial_sel_i, latch_strobe_i, parallel_weight_lines_i, shift_word};

  bit_sync #(.W(WORD_W+ATTEN_W+2)) u_sync (
    .clk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i (ce_i),
    .d_i  (raw_in),
    .q_o  (sync_in)
  );

  assign s_word  = sync_in[WORD_W-1:0];
  assign s_lines = sync_in[WORD_W+ATTEN_W-1:WORD_W];
  assign s_le    = sync_in[WORD_W+ATTEN_W];
  assign s_sel   = sync_in[WORD_W+ATTEN_W+1];
  assign le_rise = s_le & ~le_d;

  // Strobe edge history
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      le_d <= 1'b0;
    end else if (ce_i) begin
      le_d <= s_le;
    end
  end

  // Power-up sequencing
  always_comb begin
    next_state = state;
    case (state)
      step_atten_pkg::ST_PWRUP: begin
        // Wait until the synchroniser carries the real pin levels
        if (pup_cnt == CW'(`SYNC_SETTLE)) begin
          if (!s_sel && s_le) begin
            next_state = step_atten_pkg::ST_HOLD;
          end else begin
            next_state = step_atten_pkg::ST_RUN;
          end
        end
      end
      step_atten_pkg::ST_HOLD: begin
        if (pup_cnt == CW'(PUP_DELAY - 1)) begin
          next_state = step_atten_pkg::ST_RUN;
        end
      end
      step_atten_pkg::ST_RUN: next_state = step_atten_pkg::ST_RUN;
      default: next_state = step_atten_pkg::ST_PWRUP;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state <= step_atten_pkg::ST_PWRUP;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // Settle and delay counter, restarted on every state change
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pup_cnt <= '0;
    end else if (ce_i) begin
      if (state != next_state) begin
        pup_cnt <= '0;
      end else if (state != step_atten_pkg::ST_RUN) begin
        pup_cnt <= pup_cnt + CW'(1);
      end else begin
        pup_cnt <= '0;
      end
    end
  end

  // Next attenuation: serial commit, direct follow, latched commit
  always_comb begin
    next_atten = atten_state_o;
    if (state == step_atten_pkg::ST_HOLD) begin
      next_atten = `ATTEN_MAX;
    end else if (state == step_atten_pkg::ST_RUN) begin
      if (s_sel) begin
        if (s_le) begin
          next_atten = s_word[ATTEN_W:1];
        end
      end else if (s_le) begin
        next_atten = s_lines;
      end
    end
  end

  // Core state register, maximum after reset
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      atten_state_o <= `ATTEN_MAX;
    end else if (ce_i) begin
      atten_state_o <= next_atten;
    end
  end

  // Top bit of the last committed serial word
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      word_top_bit_o <= 1'b0;
    end else if (ce_i && state == step_atten_pkg::ST_RUN && s_sel && le_rise) begin
      word_top_bit_o <= s_word[WORD_W-1];
    end
  end

  assign pup_busy_o = (state != step_atten_pkg::ST_RUN);

  a_reset_max: assert property (@(posedge mclk_i) disable iff (rst_i)
    $past(rst_i) |-> atten_state_o == `ATTEN_MAX)
    else $error("state not maximum after reset");

  a_hold_max: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == step_atten_pkg::ST_HOLD |=> atten_state_o == `ATTEN_MAX)
    else $error("state left maximum during power-up hold");

  a_latched_keep: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && state == step_atten_pkg::ST_RUN && !s_le) |=> $stable(atten_state_o))
    else $error("state changed with strobe low");

  a_direct_follow: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && state == step_atten_pkg::ST_RUN && !s_sel && s_le)
      |=> atten_state_o == $past(s_lines))
    else $error("direct mode did not follow lines");

  a_serial_commit: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && state == step_atten_pkg::ST_RUN && s_sel && s_le)
      |=> atten_state_o == $past(s_word[ATTEN_W:1]))
    else $error("serial word not committed");

  a_settle_max: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && state == step_atten_pkg::ST_PWRUP) |=> atten_state_o == `ATTEN_MAX)
    else $error("state left maximum while pins settle");

  a_top_bit: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && state == step_atten_pkg::ST_RUN && s_sel && le_rise)
      |=> word_top_bit_o == $past(s_word[WORD_W-1]))
    else $error("top bit not captured");

  a_run_sticky: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == step_atten_pkg::ST_RUN |=> state == step_atten_pkg::ST_RUN)
    else $error("left run state");

  a_pwrup_once: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && state == step_atten_pkg::ST_PWRUP && pup_cnt == CW'(`SYNC_SETTLE))
      |=> state != step_atten_pkg::ST_PWRUP)
    else $error("power-up state did not resolve");

  a_hold_len: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == step_atten_pkg::ST_HOLD |-> pup_cnt < CW'(PUP_DELAY))
    else $error("power-up hold overran");
endmodule
`default_nettype wire

//--- step_atten_map.svh
`ifndef STEP_ATTEN_MAP_SVH
`define STEP_ATTEN_MAP_SVH
`define ATTEN_W         6
`define WORD_W          8
`define ATTEN_MAX       6'h3F
`define ATTEN_MIN       6'h00
`define PUP_DELAY_US    400
`define CLK_MHZ         125
`define SYNC_RST_VAL    1'b0
`define SYNC_SETTLE     2
`endif

//--- step_atten_pkg.sv
`default_nettype none
package step_atten_pkg;
  typedef enum logic [2:0] {
    ST_PWRUP  = 3'b001,
    ST_HOLD   = 3'b010,
    ST_RUN    = 3'b100
  } pup_state_e;
endpackage
`default_nettype wire

//--- bit_sync.sv
`default_nettype none
`include "step_atten_map.svh"
module bit_sync #(
  parameter int W = 1
) (
  // Clock and control
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  // Two-stage synchroniser, first stage read only by second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= {W{`SYNC_RST_VAL}};
      q_o  <= {W{`SYNC_RST_VAL}};
    end else if (ce_i) begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule
`default_nettype wire

//--- serial_shifter.sv
`default_nettype none
`include "step_atten_map.svh"
module serial_shifter #(
  parameter int W = 8
) (
  // Serial link
  input  wire logic         sclk_i,
  input  wire logic         sdata_i,
  // Shift contents
  output var  logic [W-1:0] word_o
);
  // MSB first: new bits enter at the bottom
  always_ff @(posedge sclk_i) begin
    word_o <= {word_o[W-2:0], sdata_i};
  end
endmodule
`default_nettype wire

//--- serial_host.sv
`default_nettype none
module serial_host (
  // Serial link toward the port
  output var logic sclk_o,
  output var logic sdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Clock idles low between frames
  initial begin
    sclk_o = 1'b0;
    sdata_o = 1'b0;
  end
  // One word, top bit first, 48 ns a bit
  task automatic send(input logic [7:0] w);
    for (int i = 7; i >= 0; i--) begin
      sdata_o = w[i];
      #12 sclk_o = 1'b1;
      #24 sclk_o = 1'b0;
      #12;
    end
    sdata_o = ~w[0]; // Released line shows no stale bit
  endtask
endmodule
`default_nettype wire

//--- step_attenuator_control_port_bench.sv
`default_nettype none
module step_attenuator_control_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, rst, ce, sel, le, sclk, sdata, top, busy;
  logic [5:0] lines, st, model;
  int         mismatches = 0;
  int         n_checks = 0;
  int         cycles = 0;
  int         seed = 32'h9B160140;
  // Short power-up delay keeps the run brief
  step_attenuator_control_port #(.PUP_DELAY(20)) dut (
    .mclk_i(clk), .rst_i(rst), .ce_i(ce), .serial_sel_i(sel),
    .latch_strobe_i(le), .parallel_weight_lines_i(lines),
    .sclk_i(sclk), .sdata_i(sdata), .atten_state_o(st),
    .word_top_bit_o(top), .pup_busy_o(busy));
  serial_host host (.sclk_o(sclk), .sdata_o(sdata));
  // System clock, 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude;
    if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Core state and stored top bit against the model
  task automatic check(input logic [5:0] exp);
    n_checks++;
    if ({top, st} !== {1'b0, exp}) begin
      mismatches++;
      $display("BAD %0t state %h top %b expected %h", $time, st, top, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Strobe high then low commits the word or lines
  task automatic strobe_pulse;
    le = 1'b1;
    tick(6);
    le = 1'b0;
    tick(1);
  endtask
  // Serial program: word is dB times four, top bit zero
  task automatic ser(input logic [5:0] s);
    host.send({1'b0, s, 1'b0});
    tick(1);
    check(model);
    strobe_pulse();
    model = s;
    tick(4);
    check(model);
  endtask
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    sel = 1'b1;
    le = 1'b0;
    lines = 6'h00;
    tick(3);
    rst = 1'b0;
    model = 6'h3F;
    tick(30);
    check(model);
    for (int i = 0; i < 8; i++) ser(i < 6 ? 6'h01 << i : 6'(-(i - 6)));
    repeat (3) ser(6'($random(seed)));
    sel = 1'b0;
    tick(5);
    check(model);
    // Latched parallel: lines wait for the strobe
    for (int i = 0; i < 9; i++) begin
      lines = i < 6 ? 6'h01 << i : 6'($random(seed));
      tick(5);
      check(model);
      strobe_pulse();
      model = lines;
      tick(4);
      check(model);
    end
    // Direct parallel: state follows the lines
    le = 1'b1;
    repeat (5) begin
      lines = 6'($random(seed));
      model = lines;
      tick(5);
      check(model);
    end
    // Clock enable low freezes the state
    ce = 1'b0;
    lines = 6'($random(seed));
    tick(5);
    check(model);
    ce = 1'b1;
    model = lines;
    tick(5);
    check(model);
    lines = 6'h00;
    model = 6'h00;
    tick(4);
    le = 1'b0;
    tick(4);
    check(model);
    sel = 1'b1;
    tick(4);
    ser(6'($random(seed)));
    ser(6'h2A);
    // Second reset in direct mode with lines held at zero
    rst = 1'b1;
    sel = 1'b0;
    le = 1'b1;
    lines = 6'h00;
    tick(3);
    rst = 1'b0;
    model = 6'h3F;
    tick(10);
    check(model);
    n_checks++;
    if (busy !== 1'b1) begin
      mismatches++;
      $display("BAD %0t power-up hold not busy", $time);
    end
    tick(20);
    model = 6'h00;
    check(model);
    n_checks++;
    if (busy !== 1'b0) begin
      mismatches++;
      $display("BAD %0t power-up hold did not end", $time);
    end
    conclude();
  end
endmodule
`default_nettype wire
